/* File: shared/clk_ctrl_pkg.sv */
// Constants and types for the oscillator and loop clock control
// Function
// - Valid flag low until amplitude settles
// - Reference select: zero internal, one external
// - Internal divide applies before pre-divider
// - Reference divided by five-bit pre-divider
// - Output equals reference times N over M
// - Lock flag only when loop stable
// - Both enable bits may clear together
// - Pre-divider zero divides by 32
// - Multiplier zero multiplies by 256
// - Loop held in reset while run clear
package clk_ctrl_pkg;
    localparam int CLK_MHZ          = 200;
    localparam int XTAL_SETTLE_US   = 1000;
    localparam int XTAL_SETTLE_CYC  = XTAL_SETTLE_US * CLK_MHZ;
    localparam int LOCK_TIME_US     = 20;
    localparam int LOCK_TIME_CYC    = LOCK_TIME_US * CLK_MHZ;
    localparam logic [4:0] PREDIV_RST = 5'h01;
    localparam logic [7:0] MUL_RST    = 8'h01;
    localparam logic [5:0] FLT_RST    = 6'h31;
    localparam logic [5:0] PREDIV_ZERO_DIV = 6'h20;
    localparam logic [8:0] MUL_ZERO_FACTOR = 9'h100;
    localparam logic [1:0] SRC_INTERNAL = 2'h0;
    localparam logic [1:0] SRC_EXTERNAL = 2'h1;
    localparam logic [1:0] SRC_LOOP     = 2'h2;
    localparam logic [2:0] XMODE_CRYSTAL = 3'h6;

    typedef struct packed {
        logic       reference_select;
        logic       run_enable;
        logic       bias_power;
        logic [4:0] predivide_value;
        logic [7:0] multiply_value;
        logic [3:0] loop_filter_range;
        logic [1:0] current_osc_range;
    } loop_cfg_t;

    typedef struct packed {
        logic       lock_flag;
        logic       crystal_valid_flag;
        logic [5:0] effective_div;
        logic [8:0] effective_mul;
    } loop_status_t;
endpackage

/* File: core/clk_divider.sv */
// Programmable clock-enable divider: one pulse per div_in enables
`timescale 1ns/1ps
module clk_divider
    import clk_ctrl_pkg::*;
#(
    parameter int WIDTH = 6
)(
    // Clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic             clk_en_in,
    // Divider
    input  wire logic             hold_in,
    input  wire logic             tick_in,
    input  wire logic [WIDTH-1:0] div_in,
    output logic                  tick_out
);
    logic [WIDTH-1:0] count_q;

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in || (clk_en_in && hold_in))
        begin
            count_q  <= '0;
            tick_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            tick_out <= 1'b0;
            if (tick_in)
            begin
                if (count_q >= div_in - WIDTH'(1))
                begin
                    count_q  <= '0;
                    tick_out <= 1'b1;
                end
                else
                begin
                    count_q <= count_q + WIDTH'(1);
                end
            end
        end
    end
endmodule

/* File: core/loop_clock_ctrl.sv */
// Crystal validity sequencing, loop reference path, lock and source switch
`timescale 1ns/1ps
module loop_clock_ctrl
    import clk_ctrl_pkg::*;
#(
    parameter int XTAL_CYC = XTAL_SETTLE_CYC,
    parameter int LOCK_CYC = LOCK_TIME_CYC
)(
    // Clock and reset
    input  wire logic         sys_clk_in,
    input  wire logic         sys_rst_in,
    input  wire logic         clk_en_in,
    // Oscillator inputs as enable ticks
    input  wire logic         int_osc_tick_in,
    input  wire logic         ext_osc_tick_in,
    input  wire logic [1:0]   internal_osc_divide_in,
    input  wire logic [2:0]   external_osc_mode_in,
    // Loop configuration and source select
    input  wire loop_cfg_t    cfg_in,
    input  wire logic [1:0]   clock_source_sel_in,
    // Status and clock ticks
    output loop_status_t      status_out,
    output logic              pfd_tick_out,
    output logic              sys_tick_out,
    output logic [1:0]        active_source_out
);
    // ----------------------------------------------------------------
    // Crystal settle
    // ----------------------------------------------------------------
    logic        xtal_on;
    logic [31:0] xtal_cnt_q;
    logic        xtal_valid_q;
    assign xtal_on = (external_osc_mode_in[2:1] == XMODE_CRYSTAL[2:1]);

    // valid held low until settle count ends
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in || (clk_en_in && !xtal_on))
        begin
            xtal_cnt_q   <= '0;
            xtal_valid_q <= 1'b0;
        end
        else if (clk_en_in && !xtal_valid_q)
        begin
            if (xtal_cnt_q >= 32'(XTAL_CYC - 1))
                xtal_valid_q <= 1'b1;
            else
                xtal_cnt_q <= xtal_cnt_q + 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // Reference path
    // ----------------------------------------------------------------
    function automatic logic [5:0] prediv_of(input logic [4:0] m);
        return (m == 5'h00) ? PREDIV_ZERO_DIV : {1'b0, m};
    endfunction

    function automatic logic [8:0] mul_of(input logic [7:0] n);
        return (n == 8'h00) ? MUL_ZERO_FACTOR : {1'b0, n};
    endfunction

    logic [5:0] int_div;
    logic       int_div_tick;
    logic       ref_tick;
    logic       loop_reset;
    assign int_div = 6'h1 << (2'h3 - internal_osc_divide_in);

    // internal oscillator divide before reference mux
    clk_divider #(.WIDTH(6)) u_int_div (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .clk_en_in  (clk_en_in),
        .hold_in    (1'b0),
        .tick_in    (int_osc_tick_in),
        .div_in     (int_div),
        .tick_out   (int_div_tick)
    );

    assign ref_tick = cfg_in.reference_select ? ext_osc_tick_in : int_div_tick;
    // run and bias may clear together
    // loop held in reset while run clear
    assign loop_reset = !cfg_in.run_enable || !cfg_in.bias_power;

    clk_divider #(.WIDTH(6)) u_pre_div (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .clk_en_in  (clk_en_in),
        .hold_in    (loop_reset),
        .tick_in    (ref_tick),
        .div_in     (prediv_of(cfg_in.predivide_value)),
        .tick_out   (pfd_tick_out)
    );

    // ----------------------------------------------------------------
    // Lock
    // ----------------------------------------------------------------
    logic [31:0] lock_cnt_q;
    logic        lock_q;
    loop_cfg_t   cfg_seen_q;

    // lock after stable interval of same config
    // cleared on run or bias drop
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            lock_cnt_q <= '0;
            lock_q     <= 1'b0;
            cfg_seen_q <= '0;
        end
        else if (clk_en_in)
        begin
            cfg_seen_q <= cfg_in;
            if (loop_reset || cfg_seen_q != cfg_in)
            begin
                lock_cnt_q <= '0;
                lock_q     <= 1'b0;
            end
            else if (!lock_q)
            begin
                if (lock_cnt_q >= 32'(LOCK_CYC - 1))
                    lock_q <= 1'b1;
                else
                    lock_cnt_q <= lock_cnt_q + 32'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Loop output tick: N outputs per divided reference period
    // ----------------------------------------------------------------
    logic [8:0] out_left_q;
    logic       loop_tick_q;
    // output rate is reference times N over M
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in || (clk_en_in && loop_reset))
        begin
            out_left_q  <= '0;
            loop_tick_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            loop_tick_q <= 1'b0;
            if (pfd_tick_out)
                out_left_q <= mul_of(cfg_in.multiply_value);
            else if (out_left_q != 9'h0)
            begin
                out_left_q  <= out_left_q - 9'h1;
                loop_tick_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Glitch-free source switch
    // ----------------------------------------------------------------
    logic [1:0] src_q;
    logic       cur_tick;
    always_comb
    begin
        unique case (src_q)
            SRC_EXTERNAL: cur_tick = ext_osc_tick_in;
            SRC_LOOP:     cur_tick = loop_tick_q;
            default:      cur_tick = int_div_tick;
        endcase
    end

    // change source only at old source edge
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            src_q        <= SRC_INTERNAL;
            sys_tick_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            sys_tick_out <= cur_tick;
            if (cur_tick && clock_source_sel_in != 2'h3)
                src_q <= clock_source_sel_in;
        end
    end

    assign active_source_out = src_q;
    assign status_out = '{lock_flag:          lock_q,
                          crystal_valid_flag: xtal_valid_q,
                          effective_div:      prediv_of(cfg_in.predivide_value),
                          effective_mul:      mul_of(cfg_in.multiply_value)};

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence drop_s;
        loop_reset;
    endsequence

    lock_drop_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (clk_en_in and drop_s) |=> !lock_q)
        else $error("lock held after disable");
    xtal_low_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        clk_en_in && !xtal_on |=> !xtal_valid_q)
        else $error("crystal valid without crystal");
    lock_cause_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        $rose(lock_q) |-> !$past(loop_reset))
        else $error("lock rose in reset");
    pre_hold_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        clk_en_in && loop_reset |=> !pfd_tick_out)
        else $error("pre-divider ran in reset");
    zero_div_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        cfg_in.predivide_value == 5'h00 |-> status_out.effective_div == 6'h20)
        else $error("zero pre-divide not 32");
    zero_mul_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        cfg_in.multiply_value == 8'h00 |-> status_out.effective_mul == 9'h100)
        else $error("zero multiplier not 256");
    ref_ext_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        cfg_in.reference_select |-> ref_tick == ext_osc_tick_in)
        else $error("wrong reference");
    src_edge_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        clk_en_in && !cur_tick |=> $stable(src_q))
        else $error("source switched mid period");
    out_count_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        clk_en_in && !loop_reset && pfd_tick_out
        |=> out_left_q == mul_of($past(cfg_in.multiply_value)))
        else $error("multiplier load wrong");
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the loop clock control block
`timescale 1ns/1ps
module tb;
    import clk_ctrl_pkg::*;
    localparam int XC = 20;
    localparam int LC = 10;
    logic         sys_clk_in;
    logic         sys_rst_in;
    logic         clk_en_in;
    logic         int_osc_tick_in;
    logic         ext_osc_tick_in;
    logic [1:0]   internal_osc_divide_in;
    logic [2:0]   external_osc_mode_in;
    loop_cfg_t    cfg_in;
    logic [1:0]   clock_source_sel_in;
    loop_status_t status_out;
    logic         pfd_tick_out;
    logic         sys_tick_out;
    logic [1:0]   active_source_out;
    int           fail_count;
    int           tests_run;
    int           seed;
    int           i;
    int           k;
    int           f;

    loop_clock_ctrl #(.XTAL_CYC(XC), .LOCK_CYC(LC)) u_loop_clock_ctrl (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
        .int_osc_tick_in(int_osc_tick_in), .ext_osc_tick_in(ext_osc_tick_in),
        .internal_osc_divide_in(internal_osc_divide_in),
        .external_osc_mode_in(external_osc_mode_in), .cfg_in(cfg_in),
        .clock_source_sel_in(clock_source_sel_in), .status_out(status_out),
        .pfd_tick_out(pfd_tick_out), .sys_tick_out(sys_tick_out),
        .active_source_out(active_source_out));

    initial
    begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask

    // Expected pfd ticks in n cycles for divides d and m
    function automatic int pfd_exp(input int n, input int d, input int m);
        return n / (d * m);
    endfunction

    // Pass when got lies in lo..hi
    task automatic chk(input logic [31:0] got, input int lo, input int hi);
        tests_run++;
        if ($isunknown(got) || got < lo || got > hi)
        begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    task automatic count_ticks(input logic which, input int n, output int c);
        c = 0;
        repeat (n)
        begin
            cyc(1);
            if ((which ? sys_tick_out : pfd_tick_out) === 1'b1)
                c++;
        end
    endtask

    task automatic wait_lock(output int n);
        n = 0;
        while (status_out.lock_flag !== 1'b1 && n < 60)
        begin
            cyc(1);
            n++;
        end
    endtask

    task automatic tally_and_finish;
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #100000;
        fail_count++;
        tally_and_finish();
    end

    initial
    begin
        seed = 6;
        fail_count = 0;
        tests_run = 0;
        sys_rst_in = 1'b1;
        clk_en_in = 1'b1;
        int_osc_tick_in = 1'b1;
        ext_osc_tick_in = 1'b0;
        internal_osc_divide_in = 2'h3;
        external_osc_mode_in = 3'h0;
        cfg_in = '0;
        clock_source_sel_in = 2'h0;
        cyc(10);
        sys_rst_in = 1'b0;
        cyc(2);
        // ---------------------------------
        // Divide and multiply factors
        // ---------------------------------
        for (i = 0; i < 24; i++)
        begin
            cfg_in.predivide_value = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($random(seed));
            cfg_in.multiply_value = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            cyc(1);
            k = (cfg_in.predivide_value == 5'h00) ? 32 : cfg_in.predivide_value;
            chk(status_out.effective_div, k, k);
            k = (cfg_in.multiply_value == 8'h00) ? 256 : cfg_in.multiply_value;
            chk(status_out.effective_mul, k, k);
        end
        // ---------------------------------
        // Reference path and pre-divider
        // ---------------------------------
        // bias first, then loop settings
        cfg_in.bias_power = 1'b1;
        cyc(1);
        for (i = 0; i < 4; i++)
        begin
            // reprogram only while run is clear
            cfg_in.run_enable = 1'b0;
            internal_osc_divide_in = 2'(i);
            cyc(1);
            // divided reference 6.25 MHz, output 50 MHz
            // filter and range match those rates
            cfg_in.predivide_value = 5'(4 << i);
            cfg_in.loop_filter_range = 4'hf;
            cfg_in.current_osc_range = 2'h3;
            cfg_in.multiply_value = 8'h08;
            cyc(2);
            cfg_in.run_enable = 1'b1;
            cyc(20);
            count_ticks(1'b0, 256, k);
            f = pfd_exp(256, 8 >> i, 4 << i);
            chk(k, f - 1, f + 1);
        end
        int_osc_tick_in = 1'b0;
        ext_osc_tick_in = 1'b1;
        external_osc_mode_in = 3'h2;
        cyc(20);
        count_ticks(1'b0, 100, k);
        chk(k, 0, 0);
        cfg_in.reference_select = 1'b1;
        cyc(20);
        count_ticks(1'b0, 256, k);
        f = pfd_exp(256, 1, 32);
        chk(k, f - 1, f + 1);
        cfg_in.run_enable = 1'b0;
        // ---------------------------------
        // Crystal valid sequencing
        // ---------------------------------
        external_osc_mode_in = 3'h6;
        cyc(XC - 3);
        chk(status_out.crystal_valid_flag, 0, 0);
        // Enable low freezes the settle count
        clk_en_in = 1'b0;
        cyc(XC);
        chk(status_out.crystal_valid_flag, 0, 0);
        clk_en_in = 1'b1;
        k = XC - 3;
        while (status_out.crystal_valid_flag !== 1'b1 && k < XC + 20)
        begin
            cyc(1);
            k++;
        end
        chk(k, XC - 1, XC + 3);
        external_osc_mode_in = 3'h2;
        cyc(3);
        chk(status_out.crystal_valid_flag, 0, 0);
        // ---------------------------------
        // Lock timing and lock loss
        // ---------------------------------
        for (i = 0; i < 4; i++)
        begin
            cfg_in.bias_power = 1'b1;
            cyc(1);
            cfg_in.multiply_value = 8'(4 + i);
            cyc(2);
            cfg_in.run_enable = 1'b1;
            cyc(LC - 2);
            chk(status_out.lock_flag, 0, 0);
            wait_lock(k);
            chk(k + LC - 2, LC, LC + 4);
            cyc(5);
            chk(status_out.lock_flag, 1, 1);
            if (i == 1)
                cfg_in.bias_power = 1'b0;
            else if (i == 3)
                cfg_in = loop_cfg_t'(cfg_in & ~22'h180000);
            else
                cfg_in.run_enable = 1'b0;
            cyc(2);
            chk(status_out.lock_flag, 0, 0);
            if (i == 2)
            begin
                // reprogram only while run is clear
                cfg_in.multiply_value = 8'h08;
                cyc(2);
                cfg_in.run_enable = 1'b1;
            end
            cyc(LC + 5);
            if (i == 2)
                chk(status_out.lock_flag, 1, 1);
            else if (i == 3)
                chk(status_out.lock_flag, 0, 0);
            else
                chk(status_out.lock_flag, 0, 0);
            cfg_in.run_enable = 1'b0;
            cyc(1);
        end
        // ---------------------------------
        // System clock source switching
        // ---------------------------------
        int_osc_tick_in = 1'b1;
        internal_osc_divide_in = 2'h1;
        cyc(20);
        count_ticks(1'b1, 100, k);
        chk(k, 24, 26);
        clock_source_sel_in = 2'h1;
        cyc(20);
        chk(active_source_out, 1, 1);
        clock_source_sel_in = 2'h3;
        cyc(20);
        chk(active_source_out, 1, 1);
        cfg_in.bias_power = 1'b1;
        cyc(2);
        cfg_in.run_enable = 1'b1;
        wait_lock(k);
        chk(status_out.lock_flag, 1, 1);
        clock_source_sel_in = 2'h2;
        cyc(40);
        chk(active_source_out, 2, 2);
        count_ticks(1'b1, 256, k);
        f = pfd_exp(256, 1, 32) * 7;
        chk(k, f - 7, f + 7);
        clock_source_sel_in = 2'h0;
        cyc(40);
        chk(active_source_out, 0, 0);
        sys_rst_in = 1'b1;
        cyc(2);
        sys_rst_in = 1'b0;
        cyc(1);
        chk(status_out.lock_flag, 0, 0);
        chk(active_source_out, 0, 0);
        tally_and_finish();
    end
endmodule
